// >>> verilog/dpc_host.sv
`timescale 1ns/1ns
`default_nettype none
module dpc_host #(
  parameter int ACK_TIMEOUT = dpc_pkg::DPC_ACK_TIMEOUT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // control cable
  dpc_if.host lnk
);
  import dpc_pkg::*;

  if (ACK_TIMEOUT < 2 || ACK_TIMEOUT > 255) begin : g_tmo_chk
    $error("dpc_host: ACK_TIMEOUT must lie in 2..255");
  end

  typedef enum logic [2:0] {HS_IDLE, HS_STAT, HS_RST, HS_START, HS_CMD} dpc_hstate_t;

  dpc_hstate_t state_r;
  logic auto_r;
  logic [2:0] unit_r;
  logic sw_req_r;
  logic [3:0] sw_code_r;
  logic [15:0] dstat_r;
  logic valid_r;
  logic [3:0] code_r;
  logic [7:0] tmo_r;
  logic attn_d_r;
  logic attn_pend_r;
  logic [DPC_IRQ_W-1:0] irq_stat_r;
  logic [DPC_IRQ_W-1:0] irq_mask_r;
  logic [DPC_IRQ_W-1:0] ev;
  logic wr;
  logic rd;
  logic cmd_wr;
  logic tmo_hit;
  logic take_attn;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign cmd_wr = wr && (wb_adr_i == DPC_REG_CMD);
  assign tmo_hit = valid_r && !lnk.cmd_ack && (tmo_r == 8'(ACK_TIMEOUT));
  assign take_attn = (state_r == HS_IDLE) && auto_r && attn_pend_r;

  // bus handshake, one wait cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      case (wb_adr_i)
        DPC_REG_CTRL: wb_dat_o <= {31'h0, auto_r};
        DPC_REG_UNIT: wb_dat_o <= {29'h0, unit_r};
        DPC_REG_STATUS: wb_dat_o <= {14'h0, lnk.attn, (state_r != HS_IDLE), dstat_r};
        DPC_REG_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_r};
        DPC_REG_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask_r};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_r <= DPC_CTRL_RST;
      unit_r <= DPC_UNIT_RST;
      irq_mask_r <= DPC_IRQ_MASK_RST;
    end else if (wr) begin
      case (wb_adr_i)
        DPC_REG_CTRL: auto_r <= wb_dat_i[DPC_CTRL_AUTO_BIT];
        DPC_REG_UNIT: unit_r <= wb_dat_i[2:0];
        DPC_REG_IRQ_MASK: irq_mask_r <= wb_dat_i[DPC_IRQ_W-1:0];
        default: auto_r <= auto_r;
      endcase
    end
  end

  // software command request, held until issued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_req_r <= 1'b0;
      sw_code_r <= 4'h0;
    end else if (cmd_wr) begin
      sw_req_r <= 1'b1;
      sw_code_r <= wb_dat_i[3:0];
    end else if (state_r == HS_IDLE && !take_attn) begin
      sw_req_r <= 1'b0;
    end
  end

  // attention rising edge latched until serviced
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attn_d_r <= 1'b0;
      attn_pend_r <= 1'b0;
    end else begin
      attn_d_r <= lnk.attn;
      if (lnk.attn && !attn_d_r) begin
        attn_pend_r <= 1'b1;
      end else if (take_attn) begin
        attn_pend_r <= 1'b0;
      end
    end
  end

  // ack timeout
  always_ff @(posedge clk_i) begin
    if (rst_i || !valid_r || lnk.cmd_ack) begin
      tmo_r <= 8'h00;
    end else begin
      tmo_r <= tmo_r + 8'h01;
    end
  end

  // command sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= HS_IDLE;
      valid_r <= 1'b0;
      code_r <= DPC_CMD_GET_STATUS;
      dstat_r <= 16'h0000;
    end else if (tmo_hit) begin
      valid_r <= 1'b0;
      state_r <= HS_IDLE;
    end else begin
      case (state_r)
        HS_IDLE: begin
          if (take_attn) begin
            valid_r <= 1'b1;
            code_r <= DPC_CMD_GET_STATUS;
            state_r <= HS_STAT;
          end else if (sw_req_r) begin
            valid_r <= 1'b1;
            code_r <= sw_code_r;
            state_r <= HS_CMD;
          end
        end
        HS_STAT: begin
          if (lnk.cmd_ack) begin
            dstat_r <= lnk.status;
            if (lnk.status[DPC_STAT_POR_BIT]) begin
              code_r <= DPC_CMD_RESET_ATTN;
              state_r <= HS_RST;
            end else begin
              valid_r <= 1'b0;
              state_r <= HS_IDLE;
            end
          end
        end
        HS_RST: begin
          if (lnk.cmd_ack) begin
            code_r <= DPC_CMD_START_MOTOR;
            state_r <= HS_START;
          end
        end
        HS_START, HS_CMD: begin
          if (lnk.cmd_ack) begin
            valid_r <= 1'b0;
            dstat_r <= lnk.status;
            state_r <= HS_IDLE;
          end
        end
        default: begin
          valid_r <= 1'b0;
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  // events, sticky status, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[DPC_IRQ_ATTN] = lnk.attn && !attn_d_r;
    ev[DPC_IRQ_SEQ] = (state_r == HS_START) && lnk.cmd_ack && !tmo_hit;
    ev[DPC_IRQ_CMD] = (state_r == HS_CMD) && lnk.cmd_ack && !tmo_hit;
    ev[DPC_IRQ_TMO] = tmo_hit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (wr && wb_adr_i == DPC_REG_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wb_dat_i[DPC_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);
  assign lnk.unit_sel = unit_r;
  assign lnk.cmd_valid = valid_r;
  assign lnk.cmd_code = code_r;
endmodule : dpc_host
`default_nettype wire

// >>> include/dpc_pkg.sv
`default_nettype none
package dpc_pkg;
  // link command codes
  localparam int DPC_CMD_W = 4;
  localparam logic [3:0] DPC_CMD_GET_STATUS = 4'h0;
  localparam logic [3:0] DPC_CMD_RESET_ATTN = 4'h1;
  localparam logic [3:0] DPC_CMD_START_MOTOR = 4'h2;
  localparam logic [3:0] DPC_CMD_STOP_MOTOR = 4'h3;
  // standard status word
  localparam int DPC_STAT_W = 16;
  localparam int DPC_STAT_POR_BIT = 8;
  localparam int DPC_STAT_STOPPED_BIT = 9;
  // unit addressing: 3-bit code, positions 1..7, zero invalid
  localparam int DPC_UNIT_W = 3;
  localparam int DPC_MAX_UNITS = 7;
  // configuration switch bank: bit 0 is switch 1, a set bit is ON
  localparam int DPC_SW_W = 4;
  localparam int DPC_SW_MOTOR_CTL = 0;
  localparam int DPC_SW_FMT_LO = 1;
  localparam int DPC_SW_FMT_HI = 3;
  // format code {sw2, sw3, sw4}
  localparam logic [2:0] DPC_FMT_512_34 = 3'h6;
  localparam logic [2:0] DPC_FMT_512_35 = 3'h4;
  localparam logic [2:0] DPC_FMT_512_36 = 3'h2;
  localparam logic [2:0] DPC_FMT_256_64 = 3'h0;
  localparam logic [2:0] DPC_FMT_ADDR_MARK = 3'h7;
  localparam logic [9:0] DPC_BYTES_512 = 10'h200;
  localparam logic [9:0] DPC_BYTES_256 = 10'h100;
  localparam logic [6:0] DPC_SPT_34 = 7'h22;
  localparam logic [6:0] DPC_SPT_35 = 7'h23;
  localparam logic [6:0] DPC_SPT_36 = 7'h24;
  localparam logic [6:0] DPC_SPT_64 = 7'h40;
  // cycles after reset release before synchronised pins are trusted
  localparam logic [1:0] DPC_SYNC_WAIT = 2'h3;
  // host register map (byte addresses)
  localparam logic [7:0] DPC_REG_CTRL = 8'h00;
  localparam logic [7:0] DPC_REG_UNIT = 8'h04;
  localparam logic [7:0] DPC_REG_CMD = 8'h08;
  localparam logic [7:0] DPC_REG_STATUS = 8'h0C;
  localparam logic [7:0] DPC_REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] DPC_REG_IRQ_MASK = 8'h14;
  localparam int DPC_CTRL_AUTO_BIT = 0;
  localparam logic DPC_CTRL_RST = 1'b1;
  localparam logic [2:0] DPC_UNIT_RST = 3'h1;
  localparam int DPC_ST_BUSY_BIT = 16;
  localparam int DPC_ST_ATTN_BIT = 17;
  // interrupt status bits
  localparam int DPC_IRQ_W = 4;
  localparam int DPC_IRQ_ATTN = 0;
  localparam int DPC_IRQ_SEQ = 1;
  localparam int DPC_IRQ_CMD = 2;
  localparam int DPC_IRQ_TMO = 3;
  localparam logic [3:0] DPC_IRQ_MASK_RST = 4'h0;
  localparam int DPC_ACK_TIMEOUT = 255;
endpackage : dpc_pkg
`default_nettype wire

// >>> include/dpc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dpc_if;
  logic [2:0] unit_sel;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic cmd_ack;
  logic attn;
  logic [15:0] status;
  modport drive (
    input unit_sel,
    input cmd_valid,
    input cmd_code,
    output cmd_ack,
    output attn,
    output status
  );
  modport host (
    output unit_sel,
    output cmd_valid,
    output cmd_code,
    input cmd_ack,
    input attn,
    input status
  );
endinterface : dpc_if
`default_nettype wire

// >>> verilog/dpc_drive.sv
`timescale 1ns/1ns
`default_nettype none
module dpc_drive #(
  parameter int NUM_POS = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control cable
  dpc_if.drive lnk,
  // straps
  input wire logic [dpc_pkg::DPC_SW_W-1:0] config_switch_bank_i,
  input wire logic [NUM_POS-1:0] unit_address_header_i,
  // drive-side results
  output logic spindle_run_o,
  output logic addr_mark_mode_o,
  output logic hard_sector_o,
  output logic factory_test_fmt_o,
  output logic [9:0] sector_bytes_o,
  output logic [6:0] sectors_per_track_o,
  output logic [2:0] unit_addr_o,
  output logic unit_valid_o
);
  import dpc_pkg::*;

  if (NUM_POS != DPC_MAX_UNITS) begin : g_pos_chk
    $error("dpc_drive: NUM_POS must equal the unit count of a 3-bit address");
  end

  typedef enum logic {DS_SYNC, DS_RUN} dpc_dstate_t;

  dpc_dstate_t state_r;
  logic [1:0] wait_r;
  logic [DPC_SW_W-1:0] sw_s1_r;
  logic [DPC_SW_W-1:0] sw_s2_r;
  logic [NUM_POS-1:0] hdr_s1_r;
  logic [NUM_POS-1:0] hdr_s2_r;
  logic attn_r;
  logic por_r;
  logic stopped_r;
  logic spin_r;
  logic ack_r;
  logic [2:0] unit_r;
  logic unit_ok_r;
  logic [2:0] unit_nxt;
  logic unit_ok_nxt;
  logic [2:0] fmt;
  logic hit;
  logic init_go;

  // two-flop synchronisers for the straps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_s1_r <= '0;
      sw_s2_r <= '0;
      hdr_s1_r <= '0;
      hdr_s2_r <= '0;
    end else begin
      sw_s1_r <= config_switch_bank_i;
      sw_s2_r <= sw_s1_r;
      hdr_s1_r <= unit_address_header_i;
      hdr_s2_r <= hdr_s1_r;
    end
  end

  // wait for synchronisers to settle after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= DS_SYNC;
      wait_r <= '0;
    end else begin
      case (state_r)
        DS_SYNC: begin
          if (wait_r == DPC_SYNC_WAIT) begin
            state_r <= DS_RUN;
          end else begin
            wait_r <= wait_r + 2'h1;
          end
        end
        DS_RUN: state_r <= DS_RUN;
        default: state_r <= DS_SYNC;
      endcase
    end
  end

  assign init_go = (state_r == DS_SYNC) && (wait_r == DPC_SYNC_WAIT);

  // one-hot jumper decode, anything else is no unit
  always_comb begin
    unit_nxt = 3'h0;
    unit_ok_nxt = 1'b0;
    for (int i = 0; i < NUM_POS; i++) begin
      if (hdr_s2_r[i]) begin
        unit_nxt = 3'(i + 1);
      end
    end
    unit_ok_nxt = ($countones(hdr_s2_r) == 1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_r <= 3'h0;
      unit_ok_r <= 1'b0;
    end else begin
      unit_r <= unit_nxt;
      unit_ok_r <= unit_ok_nxt && (state_r == DS_RUN);
    end
  end

  // command only taken by a valid, addressed unit
  assign hit = lnk.cmd_valid && unit_ok_r && (lnk.unit_sel == unit_r) && (state_r == DS_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= hit && !ack_r;
    end
  end

  // attention and power-on condition, motor strap caught once at init
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attn_r <= 1'b0;
      por_r <= 1'b0;
    end else if (init_go) begin
      attn_r <= sw_s2_r[DPC_SW_MOTOR_CTL];
      por_r <= sw_s2_r[DPC_SW_MOTOR_CTL];
    end else if (hit && !ack_r && lnk.cmd_code == DPC_CMD_RESET_ATTN) begin
      attn_r <= 1'b0;
      por_r <= 1'b0;
    end
  end

  // spindle control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spin_r <= 1'b0;
      stopped_r <= 1'b1;
    end else if (init_go) begin
      spin_r <= !sw_s2_r[DPC_SW_MOTOR_CTL];
      stopped_r <= sw_s2_r[DPC_SW_MOTOR_CTL];
    end else if (hit && !ack_r) begin
      case (lnk.cmd_code)
        DPC_CMD_START_MOTOR: begin
          spin_r <= 1'b1;
          stopped_r <= 1'b0;
        end
        DPC_CMD_STOP_MOTOR: begin
          spin_r <= 1'b0;
          stopped_r <= 1'b1;
        end
        default: begin
          spin_r <= spin_r;
          stopped_r <= stopped_r;
        end
      endcase
    end
  end

  // sector format decode
  assign fmt = sw_s2_r[DPC_SW_FMT_HI:DPC_SW_FMT_LO];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_mark_mode_o <= 1'b0;
      hard_sector_o <= 1'b0;
      factory_test_fmt_o <= 1'b0;
      sector_bytes_o <= 10'h000;
      sectors_per_track_o <= 7'h00;
    end else begin
      addr_mark_mode_o <= 1'b0;
      hard_sector_o <= 1'b1;
      factory_test_fmt_o <= 1'b0;
      sector_bytes_o <= DPC_BYTES_512;
      // code is {sw2, sw3, sw4}; sw2 sits in the lowest format bit
      case ({fmt[0], fmt[1], fmt[2]})
        DPC_FMT_512_34: sectors_per_track_o <= DPC_SPT_34;
        DPC_FMT_512_35: sectors_per_track_o <= DPC_SPT_35;
        DPC_FMT_512_36: sectors_per_track_o <= DPC_SPT_36;
        DPC_FMT_256_64: begin
          sector_bytes_o <= DPC_BYTES_256;
          sectors_per_track_o <= DPC_SPT_64;
        end
        DPC_FMT_ADDR_MARK: begin
          addr_mark_mode_o <= 1'b1;
          hard_sector_o <= 1'b0;
          sector_bytes_o <= 10'h000;
          sectors_per_track_o <= 7'h00;
        end
        default: begin
          // test-only formats: no sectoring in the field
          factory_test_fmt_o <= 1'b1;
          hard_sector_o <= 1'b0;
          sector_bytes_o <= 10'h000;
          sectors_per_track_o <= 7'h00;
        end
      endcase
    end
  end

  // link outputs
  assign lnk.cmd_ack = ack_r;
  assign lnk.attn = attn_r;
  always_comb begin
    lnk.status = '0;
    lnk.status[DPC_STAT_POR_BIT] = por_r;
    lnk.status[DPC_STAT_STOPPED_BIT] = stopped_r;
  end

  assign spindle_run_o = spin_r;
  assign unit_addr_o = unit_r;
  assign unit_valid_o = unit_ok_r;
endmodule : dpc_drive
`default_nettype wire

// >>> tb/dpc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dpc_checker
  import dpc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control cable
  input wire logic [2:0] unit_sel,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_ack,
  input wire logic attn,
  input wire logic [15:0] status
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // command of code c answered now
  sequence s_acked(logic [3:0] c);
    $rose(cmd_ack) && $past(cmd_code) == c;
  endsequence
  // power-on state, no answer next cycle
  sequence s_por_idle;
    status[DPC_STAT_POR_BIT] && status[DPC_STAT_STOPPED_BIT] ##1 !cmd_ack;
  endsequence
  a_ack_single: assert property (cmd_ack |=> !cmd_ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(cmd_ack) |-> $past(cmd_valid) && $past(unit_sel) != 3'h0)
    else $error("ack without addressed request");
  a_hold_stopped: assert property (s_por_idle |-> status[DPC_STAT_STOPPED_BIT])
    else $error("spindle left stopped state unasked");
  a_por_bits: assert property (status[DPC_STAT_POR_BIT] |-> attn && status[DPC_STAT_STOPPED_BIT])
    else $error("power-on bit without attention");
  a_attn_rise: assert property ($rose(attn) |-> status[DPC_STAT_POR_BIT] && status[DPC_STAT_STOPPED_BIT])
    else $error("attention rose without power-on bits");
  a_attn_cleared: assert property (s_acked(DPC_CMD_RESET_ATTN) |-> !attn && !status[DPC_STAT_POR_BIT])
    else $error("attention not cleared");
  a_start_clears: assert property (s_acked(DPC_CMD_START_MOTOR) |-> !status[DPC_STAT_STOPPED_BIT])
    else $error("stopped bit kept after start");
  a_start_order: assert property (cmd_valid && cmd_code == DPC_CMD_START_MOTOR |-> !attn)
    else $error("start sent with attention pending");
  a_por_repeat: assert property (s_acked(DPC_CMD_GET_STATUS) ##0 status[DPC_STAT_POR_BIT]
    |-> ##[1:20] cmd_valid && cmd_code == DPC_CMD_RESET_ATTN)
    else $error("power-on bit seen, no attention reset");
endmodule : dpc_checker
`default_nettype wire

// >>> tb/disk_power_on_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module disk_power_on_config_tb;
  import dpc_pkg::*;
  localparam logic [15:0] ST_STOP = 16'h0001 << DPC_STAT_STOPPED_BIT;
  localparam logic [15:0] ST_POR = ST_STOP | (16'h0001 << DPC_STAT_POR_BIT);
  localparam logic [15:0] CMDS = {4'hF, DPC_CMD_START_MOTOR, DPC_CMD_GET_STATUS, DPC_CMD_STOP_MOTOR};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [3:0] cfg_sw = 4'h0;
  logic [6:0] hdr = 7'h00;
  logic [31:0] wb_rdat;
  logic wb_ack, irq, spin, am, hs, ft, uvalid;
  logic [9:0] bytes;
  logic [6:0] spt;
  logic [2:0] uaddr;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 32'h9E9C75F9;

  always #25 clk_i = ~clk_i;

  dpc_if lnk();
  dpc_drive u_dpc_drive (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .config_switch_bank_i(cfg_sw),
    .unit_address_header_i(hdr), .spindle_run_o(spin), .addr_mark_mode_o(am),
    .hard_sector_o(hs), .factory_test_fmt_o(ft), .sector_bytes_o(bytes),
    .sectors_per_track_o(spt), .unit_addr_o(uaddr), .unit_valid_o(uvalid));
  dpc_host #(.ACK_TIMEOUT(8)) u_dpc_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .lnk(lnk));
  dpc_checker u_dpc_checker (.clk_i(clk_i), .rst_i(rst_i), .unit_sel(lnk.unit_sel),
    .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code), .cmd_ack(lnk.cmd_ack),
    .attn(lnk.attn), .status(lnk.status));

  function automatic logic [19:0] exp_fmt(input logic [2:0] f);
    case (f)
      DPC_FMT_512_34: return {3'b010, DPC_BYTES_512, DPC_SPT_34};
      DPC_FMT_512_35: return {3'b010, DPC_BYTES_512, DPC_SPT_35};
      DPC_FMT_512_36: return {3'b010, DPC_BYTES_512, DPC_SPT_36};
      DPC_FMT_256_64: return {3'b010, DPC_BYTES_256, DPC_SPT_64};
      DPC_FMT_ADDR_MARK: return {3'b100, 17'h0};
      default: return {3'b001, 17'h0};
    endcase
  endfunction : exp_fmt

  // {valid, highest installed position}
  function automatic logic [3:0] exp_unit(input logic [6:0] h);
    int c;
    logic [2:0] a;
    c = 0;
    a = 3'h0;
    for (int k = 0; k < DPC_MAX_UNITS; k++) begin
      if (h[k]) begin
        c++;
        a = 3'(k + 1);
      end
    end
    return {c == 1, a};
  endfunction : exp_unit

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ack wait is cut short only by the watchdog
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb_xfer

  task automatic wait_irq(input logic [3:0] m);
    logic [31:0] q;
    int n;
    q = 32'h0;
    n = 0;
    while ((q[3:0] & m) === 4'h0 && n < 40) begin
      wb_xfer(1'b0, DPC_REG_IRQ_STAT, 32'h0, q);
      n++;
    end
    if (n >= 40) n_errors++;
  endtask : wait_irq

  task automatic run_case(input logic [3:0] sw, input logic [6:0] h);
    logic [3:0] u;
    logic [31:0] q;
    logic run;
    u = exp_unit(h);
    run = !sw[0] || u[3];
    @(posedge clk_i);
    rst_i <= 1'b1;
    cfg_sw <= sw;
    hdr <= h;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b1, DPC_REG_UNIT, {29'h0, u[2:0]}, q);
    if (sw[0]) wait_irq(4'(1 << DPC_IRQ_SEQ | 1 << DPC_IRQ_TMO));
    else repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check(32'({am, hs, ft, bytes, spt}), 32'(exp_fmt({sw[1], sw[2], sw[3]})));
    check(32'({uvalid, uaddr}), 32'(u));
    check(32'(spin), 32'(run));
    check(32'(lnk.attn), 32'(!run));
    check(32'(lnk.status), 32'(run ? 16'h0 : ST_POR));
  endtask : run_case

  initial begin
    logic [31:0] q;
    logic [2:0] f;
    logic [6:0] h;
    for (int i = 0; i < 12; i++) begin
      f = (i < 8) ? 3'(i) : 3'($random(seed));
      h = (i % 4 == 0) ? 7'h00 : 7'($random(seed));
      if (i % 4 == 1 || i % 4 == 2) h = 7'(7'h01 << ($unsigned($random(seed)) % 7));
      run_case({f[0], f[1], f[2], 1'($random(seed))}, h);
    end
    run_case(4'h3, 7'h04);
    check(32'(irq), 32'h0);
    wb_xfer(1'b0, DPC_REG_IRQ_STAT, 32'h0, q);
    check(q, 32'(1 << DPC_IRQ_ATTN | 1 << DPC_IRQ_SEQ));
    wb_xfer(1'b1, DPC_REG_IRQ_MASK, 32'(1 << DPC_IRQ_SEQ), q);
    @(negedge clk_i);
    check(32'(irq), 32'h1);
    wb_xfer(1'b1, DPC_REG_IRQ_STAT, 32'(1 << DPC_IRQ_SEQ), q);
    @(negedge clk_i);
    check(32'(irq), 32'h0);
    wb_xfer(1'b0, DPC_REG_IRQ_STAT, 32'h0, q);
    check(q, 32'(1 << DPC_IRQ_ATTN));
    wb_xfer(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    wb_xfer(1'b0, DPC_REG_CTRL, 32'h0, q);
    check(q, 32'(DPC_CTRL_RST));
    wb_xfer(1'b0, DPC_REG_UNIT, 32'h0, q);
    check(q, 32'h3);
    wb_xfer(1'b1, DPC_REG_CTRL, 32'h0, q);
    wb_xfer(1'b0, DPC_REG_CTRL, 32'h0, q);
    check(q, 32'h0);
    // stop, status, start, unknown code
    for (int k = 0; k < 4; k++) begin
      wb_xfer(1'b1, DPC_REG_CMD, {28'h0, CMDS[k*4 +: 4]}, q);
      wait_irq(4'(1 << DPC_IRQ_CMD));
      wb_xfer(1'b1, DPC_REG_IRQ_STAT, 32'(1 << DPC_IRQ_CMD), q);
      wb_xfer(1'b0, DPC_REG_STATUS, 32'h0, q);
      check(q, 32'((k < 2) ? ST_STOP : 16'h0));
      @(negedge clk_i);
      check(32'(spin), 32'(k >= 2));
    end
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
endmodule : disk_power_on_config_tb
`default_nettype wire
